// ### hdl/rwd_watchdog.sv
// runaway watchdog top
`timescale 1ns/1ps
`include "rwd_defs.svh"
module rwd_watchdog (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // core instruction strobes, one cycle each
    input wire rwd_pkg::rwd_core_t core,
    // answers to core
    output logic skip,
    output rwd_pkg::rwd_flags_t flags,
    output logic [`RWD_CNT_W-1:0] watchdog_down_counter,
    // reset pin pull-down
    output logic reset_pin_out,
    output logic reset_pin_oe
);
    logic first_underflow_flag;
    logic second_underflow_flag;
    logic watchdog_enable_flag;
    logic disable_pending;
    rwd_pkg::rwd_state_t state;
    rwd_pkg::rwd_state_t next_state;
    wire logic underflow;
    wire logic fire;
    wire logic disable_now;
    wire logic clear_now;

    rwd_counter rwd_counter_i (
        .clock(clock),
        .rstn(rstn),
        .init(core.ram_backup_entry),
        .tick(core.tick),
        .count(watchdog_down_counter),
        .underflow(underflow)
    );

    // a new instruction on each tick; the pending disable lasts one instruction
    assign clear_now = core.clear_and_skip_instr && first_underflow_flag;
    assign disable_now = core.clear_and_skip_instr && disable_pending;
    assign fire = underflow && first_underflow_flag && watchdog_enable_flag
        && !core.ram_backup_entry;

    always_comb begin
        case (state)
            rwd_pkg::rwd_run: next_state = first_underflow_flag ? rwd_pkg::rwd_armed : rwd_pkg::rwd_run;
            rwd_pkg::rwd_armed: begin
                if (fire) begin
                    next_state = rwd_pkg::rwd_reset;
                end else if (!first_underflow_flag) begin
                    next_state = rwd_pkg::rwd_run;
                end else begin
                    next_state = rwd_pkg::rwd_armed;
                end
            end
            rwd_pkg::rwd_reset: next_state = rwd_pkg::rwd_reset;
            default: next_state = rwd_pkg::rwd_run;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            first_underflow_flag <= 1'b0;
            second_underflow_flag <= 1'b0;
            watchdog_enable_flag <= 1'b1;
            disable_pending <= 1'b0;
            state <= rwd_pkg::rwd_run;
        end else begin
            state <= next_state;
            if (core.ram_backup_entry) begin
                first_underflow_flag <= 1'b0;
                watchdog_enable_flag <= 1'b1;
                disable_pending <= 1'b0;
            end else begin
                // set wins over clear
                if (underflow) begin
                    first_underflow_flag <= 1'b1;
                end else if (clear_now) begin
                    first_underflow_flag <= 1'b0;
                end
                if (fire) begin
                    second_underflow_flag <= 1'b1;
                end
                if (disable_now) begin
                    watchdog_enable_flag <= 1'b0;
                end
                if (core.watchdog_disable_instr) begin
                    disable_pending <= 1'b1;
                end else if (core.clear_and_skip_instr || core.tick) begin
                    disable_pending <= 1'b0;
                end
            end
        end
    end

    assign skip = clear_now;
    assign flags = '{first_underflow_flag, second_underflow_flag, watchdog_enable_flag};
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = (state == rwd_pkg::rwd_reset);
endmodule

// ### hdl/rwd_defs.svh
// constants for the runaway watchdog
`ifndef RWD_DEFS_SVH
`define RWD_DEFS_SVH
`define RWD_CNT_W 16
`define RWD_CNT_INIT 16'hffff
`define RWD_CNT_ZERO 16'h0000
`define RWD_CNT_STEP 16'h0001
`endif

// ### hdl/rwd_pkg.sv
// types for the runaway watchdog
package rwd_pkg;
    typedef struct packed {
        logic tick;
        logic clear_and_skip_instr;
        logic watchdog_disable_instr;
        logic ram_backup_entry;
    } rwd_core_t;
    typedef struct packed {
        logic first_underflow_flag;
        logic second_underflow_flag;
        logic watchdog_enable_flag;
    } rwd_flags_t;
    typedef enum logic [2:0] {
        rwd_run = 3'h1,
        rwd_armed = 3'h2,
        rwd_reset = 3'h4
    } rwd_state_t;
endpackage

// ### hdl/rwd_counter.sv
// watchdog down counter with underflow pulse
`timescale 1ns/1ps
`include "rwd_defs.svh"
module rwd_counter (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // control
    input wire logic init,
    input wire logic tick,
    // status
    output logic [`RWD_CNT_W-1:0] count,
    output logic underflow
);
    wire logic at_zero;
    logic [`RWD_CNT_W-1:0] next_count;
    assign at_zero = (count == `RWD_CNT_ZERO);
    assign next_count = init ? `RWD_CNT_INIT : (tick ? count - `RWD_CNT_STEP : count);
    always_ff @(posedge clock) begin
        if (!rstn) begin
            count <= `RWD_CNT_INIT;
            underflow <= 1'b0;
        end else begin
            count <= next_count;
            underflow <= tick && at_zero && !init;
        end
    end
endmodule

// ### bench/rwd_watchdog_properties.sv
// watchdog port checker
`timescale 1ns/1ps
module rwd_watchdog_properties (
    // watched ports
    input wire logic clock,
    input wire logic rstn,
    input wire rwd_pkg::rwd_core_t core,
    input wire logic skip,
    input wire rwd_pkg::rwd_flags_t flags,
    input wire logic [15:0] watchdog_down_counter,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe
);
    wire [15:0] cnt = watchdog_down_counter;
    wire f1 = flags.first_underflow_flag;
    wire en = flags.watchdog_enable_flag;
    wire bk = core.ram_backup_entry;
    wire cs = core.clear_and_skip_instr;
    wire wrap = core.tick && cnt == 16'h0 && !bk;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_count_step: assert property (core.tick && cnt != 16'h0 && !bk |=> cnt == $past(cnt) - 16'h1)
        else $error("count step");
    a_first_set: assert property (wrap ##1 !bk |=> f1)
        else $error("first flag");
    a_skip_cause: assert property (skip == (cs && f1))
        else $error("skip");
    a_flag_clear: assert property (cs && f1 && !$past(wrap) |=> !f1)
        else $error("flag clear");
    a_second_fire: assert property (wrap ##1 f1 && en && !bk |=> flags.second_underflow_flag && reset_pin_oe)
        else $error("second underflow");
    a_gate_enable: assert property (!en && !reset_pin_oe |=> !reset_pin_oe)
        else $error("reset while disabled");
    a_backup_init: assert property (bk |=> cnt == 16'hffff && !f1 && en)
        else $error("backup");
    a_disable_alone: assert property (en && core.watchdog_disable_instr && !cs |=> en)
        else $error("lone disable");
    a_pair_clears: assert property (core.watchdog_disable_instr && !core.tick && !bk ##1 cs && !bk |=> !en)
        else $error("pair");
    a_pin_cause: assert property (reset_pin_oe |-> flags.second_underflow_flag && !reset_pin_out)
        else $error("pin");
endmodule
bind rwd_watchdog rwd_watchdog_properties rwd_watchdog_properties_i (.clock, .rstn, .core, .skip, .flags,
    .watchdog_down_counter, .reset_pin_out, .reset_pin_oe);

// ### bench/rwd_core.sv
// core model issuing watchdog strobes
`timescale 1ns/1ps
module rwd_core (
    // clock and answer
    input wire logic clock,
    input wire logic skip,
    // strobes
    output rwd_pkg::rwd_core_t core
);
    initial core = '0;
    task run(input int n);
        repeat (n) begin
            @(posedge clock);
            core.tick <= 1'b1;
        end
        @(posedge clock);
        core.tick <= 1'b0;
    endtask
    // two instructions back to back, skip seen on the second
    task op(input rwd_pkg::rwd_core_t a, input rwd_pkg::rwd_core_t b, output logic s);
        @(posedge clock);
        core <= a;
        @(posedge clock);
        core <= b;
        @(posedge clock);
        s = skip;
        core <= '0;
    endtask
endmodule

// ### bench/rwd_watchdog_test.sv
// bench for the runaway watchdog
`timescale 1ns/1ps
module rwd_watchdog_test;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic skip, reset_pin_out, reset_pin_oe, s;
    rwd_pkg::rwd_core_t core;
    rwd_pkg::rwd_flags_t flags;
    logic [15:0] cnt;
    int mismatches = 0;
    int checks_done = 0;
    always #2.5 clock = ~clock;
    rwd_core rwd_core_i (.clock, .skip, .core);
    rwd_watchdog rwd_watchdog_i (.clock, .rstn, .core, .skip, .flags, .watchdog_down_counter(cnt),
        .reset_pin_out, .reset_pin_oe);
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task t_lone_disable;
        rwd_core_i.op(4'h2, 4'h8, s);
        rwd_core_i.op(4'h0, 4'h4, s);
        chk(16'(s), 16'h0, "skip");
        @(posedge clock);
        chk(16'(flags), 16'h1, "flags");
        chk(cnt, 16'hfffe, "count");
    endtask
    task t_wrap;
        rwd_core_i.op(4'h4, 4'h0, s);
        rwd_core_i.op(4'h0, 4'h1, s);
        rwd_core_i.run(65536);
        repeat (3) @(posedge clock);
        chk(16'(flags), 16'h5, "flags");
        chk(cnt, 16'hffff, "count");
        rwd_core_i.op(4'h0, 4'h4, s);
        chk(16'(s), 16'h1, "skip");
    endtask
    task t_pair;
        rwd_core_i.op(4'h2, 4'h4, s);
        @(posedge clock);
        chk(16'(flags), 16'h0, "flags");
        rwd_core_i.op(4'h8, 4'h1, s);
        @(posedge clock);
        chk({15'h0, reset_pin_oe}, 16'h0, "pin");
        chk(cnt, 16'hffff, "count");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        t_lone_disable();
        t_wrap();
        t_pair();
        conclude();
    end
endmodule
